// ==== include/scan_beacon_pkg.sv ====
// Constants, enumerations and carrier structs for the scan and beacon settings block
package scan_beacon_pkg;

    // Frame framing bytes
    localparam logic [7:0] FRAME_START = 8'h02;
    localparam logic [7:0] setting_write_request = 8'h11;
    localparam logic [7:0] setting_read_request = 8'h10;
    localparam logic [7:0] setting_write_confirm = 8'h51;
    localparam logic [7:0] setting_read_confirm = 8'h50;

    // Confirm status values
    localparam logic [7:0] STATUS_OK = 8'h00;
    localparam logic [7:0] STATUS_FAIL = 8'h01;

    // Settings indices held by this block
    localparam logic [7:0] IDX_SECURITY = 8'h0c;
    localparam logic [7:0] IDX_SCAN = 8'h0d;
    localparam logic [7:0] IDX_BEACON = 8'h0e;

    // Reset values of the settings
    localparam logic [7:0] SECURITY_RESET = 8'h00;
    localparam logic [7:0] SCAN_RESET = 8'h00;
    localparam logic [7:0] BEACON_RESET = 8'h00;

    // Scan behaviour field layout
    localparam int SCAN_ACTIVE_BIT = 0;
    localparam logic [7:0] SCAN_WRITE_MASK = 8'h01;

    // Beacon reception mode codes
    localparam logic [7:0] BEACON_OFF = 8'h00;
    localparam logic [7:0] BEACON_INTERPRET = 8'h01;
    localparam logic [7:0] BEACON_RAW = 8'h02;
    localparam logic [7:0] BEACON_FILTERED = 8'h03;
    localparam logic [7:0] BEACON_SIGNAL = 8'h04;

    // Response byte positions
    localparam logic [2:0] POS_START = 3'h0;
    localparam logic [2:0] POS_CMD = 3'h1;
    localparam logic [2:0] POS_LEN_LO = 3'h2;
    localparam logic [2:0] POS_LEN_HI = 3'h3;
    localparam logic [2:0] POS_STATUS = 3'h4;
    localparam logic [2:0] POS_VALUE = 3'h5;
    localparam logic [2:0] POS_LAST_SHORT = 3'h5;
    localparam logic [2:0] POS_LAST_LONG = 3'h6;
    localparam logic [7:0] LEN_SHORT = 8'h01;
    localparam logic [7:0] LEN_LONG = 8'h02;

    // Advertising store size
    localparam int DB_DEPTH = 25;
    localparam logic [4:0] DB_LAST = 5'h18;

    // Frame receive states
    typedef enum logic [2:0] {
        RX_IDLE = 3'b000,
        RX_CMD = 3'b001,
        RX_LEN_LO = 3'b010,
        RX_LEN_HI = 3'b011,
        RX_PAYLOAD = 3'b100,
        RX_CSUM = 3'b101,
        RX_RESP = 3'b110
    } rx_state_e;

    // Report kinds to the host
    typedef enum logic [1:0] {
        REP_BEACON = 2'b00,
        REP_RAW = 2'b01,
        REP_SIGNAL = 2'b10
    } report_kind_e;

    // One received advertising or scan response packet
    typedef struct packed {
        logic valid;
        logic scan_rsp;
        logic family;
        logic spp_uuid;
        logic [47:0] sender_radio_address;
        logic [15:0] content_tag;
        logic [7:0] rssi;
        logic [7:0] tx_level;
    } adv_s;

    // One report towards the host
    typedef struct packed {
        report_kind_e kind;
        logic [47:0] sender_radio_address;
        logic [15:0] content_tag;
        logic [7:0] rssi;
        logic [7:0] tx_level;
    } report_s;

    // One entry of the advertising store
    typedef struct packed {
        logic used;
        logic [47:0] addr;
        logic [15:0] tag;
    } db_entry_s;

endpackage

// ==== hdl/adv_database.sv ====
// Advertising store of 25 senders with duplicate detection and oldest eviction
`timescale 1ns/1ps
module adv_database
    import scan_beacon_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire adv_s look,
    input wire logic store,
    output logic duplicate
);

    // Whole state: entries and insertion pointer
    typedef struct packed {
        db_entry_s [DB_DEPTH-1:0] ent;
        logic [4:0] wr_ptr;
    } db_state_s;

    db_state_s state_reg; // Registered store
    db_state_s state_next; // Next store
    logic found; // Sender already known
    logic [4:0] found_idx; // Slot of known sender

    // Lookup and update of the store
    always_comb begin
        state_next = state_reg;
        found = 1'b0;
        found_idx = 5'h00;
        duplicate = 1'b0;
        for (int i = 0; i < DB_DEPTH; i++) begin
            // Match on sender address
            if (state_reg.ent[i].used && state_reg.ent[i].addr == look.sender_radio_address) begin
                found = 1'b1;
                found_idx = 5'(i);
            end
        end
        // Same sender and same content already in the store
        if (found && state_reg.ent[found_idx].tag == look.content_tag) begin
            duplicate = 1'b1;
        end
        if (store) begin
            if (found) begin
                // Known sender, refresh its content
                state_next.ent[found_idx].tag = look.content_tag;
            end else begin
                state_next.ent[state_reg.wr_ptr].used = 1'b1;
                state_next.ent[state_reg.wr_ptr].addr = look.sender_radio_address;
                state_next.ent[state_reg.wr_ptr].tag = look.content_tag;
                state_next.wr_ptr = (state_reg.wr_ptr == DB_LAST) ? 5'h00 : state_reg.wr_ptr + 5'h01;
            end
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

endmodule // adv_database

// ==== hdl/radio_scan_beacon_settings.sv ====
// Command frame handler for scan and beacon settings with beacon reception
`timescale 1ns/1ps
module radio_scan_beacon_settings
    import scan_beacon_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    output logic rx_ready,
    output logic [7:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    input wire logic scan_running,
    input wire adv_s adv,
    output logic active_scan,
    output logic scan_req,
    output logic [47:0] scan_req_addr,
    output report_s report,
    output logic report_valid
);

    // Whole state of the block
    typedef struct packed {
        rx_state_e st;
        logic [7:0] cmd;
        logic [15:0] len;
        logic [15:0] cnt;
        logic [7:0] index;
        logic [7:0] value;
        logic [7:0] cs;
        logic [7:0] r_cmd;
        logic [7:0] r_status;
        logic [7:0] r_value;
        logic r_two;
        logic [2:0] r_pos;
        logic [7:0] r_cs;
        logic [7:0] tx_data;
        logic tx_valid;
        logic [7:0] security;
        logic [7:0] scan;
        logic [7:0] beacon;
        report_s rep;
        logic rep_valid;
        logic scan_req;
        logic [47:0] scan_addr;
    } state_s;

    state_s state_reg; // Registered state
    state_s state_next; // Next state
    logic rx_take; // Byte accepted this cycle
    logic tx_take; // Byte sent this cycle
    logic beacon_on; // A defined beacon mode other than off is set
    logic active_now; // Active scanning in force
    logic duplicate; // Packet seen before
    logic db_store; // Write packet to store
    logic [7:0] resp_byte; // Byte at current response position
    logic [2:0] last_pos; // Position of checksum byte
    logic settings_ok; // Request names a held setting

    // Advertising store
    adv_database u_db (
        .clk(clk),
        .rst_b(rst_b),
        .look(adv),
        .store(db_store),
        .duplicate(duplicate)
    );

    // Handshakes and outputs
    assign rx_ready = (state_reg.st != RX_RESP);
    assign rx_take = rx_valid && rx_ready;
    assign tx_take = state_reg.tx_valid && tx_ready;
    assign tx_data = state_reg.tx_data;
    assign tx_valid = state_reg.tx_valid;
    assign report = state_reg.rep;
    assign report_valid = state_reg.rep_valid;
    assign scan_req = state_reg.scan_req;
    assign scan_req_addr = state_reg.scan_addr;
    assign active_scan = active_now;

    // Mode decode
    always_comb begin
        // only codes 1 to 4 act
        beacon_on = (state_reg.beacon >= BEACON_INTERPRET) && (state_reg.beacon <= BEACON_SIGNAL);
        active_now = state_reg.scan[SCAN_ACTIVE_BIT] || beacon_on;
        db_store = adv.valid && scan_running && beacon_on;
        settings_ok = (state_reg.index == IDX_SECURITY) || (state_reg.index == IDX_SCAN)
            || (state_reg.index == IDX_BEACON);
    end

    // Response byte selection
    always_comb begin
        last_pos = state_reg.r_two ? POS_LAST_LONG : POS_LAST_SHORT;
        case (state_reg.r_pos)
            POS_START: resp_byte = FRAME_START;
            POS_CMD: resp_byte = state_reg.r_cmd;
            POS_LEN_LO: resp_byte = state_reg.r_two ? LEN_LONG : LEN_SHORT;
            POS_LEN_HI: resp_byte = 8'h00;
            POS_STATUS: resp_byte = state_reg.r_status;
            default: begin
                if (state_reg.r_pos == last_pos) begin
                    resp_byte = state_reg.r_cs;
                end else begin
                    resp_byte = state_reg.r_value;
                end
            end
        endcase
    end

    // Frame engine and beacon reporting
    always_comb begin
        state_next = state_reg;
        state_next.rep_valid = 1'b0;
        state_next.scan_req = 1'b0;

        case (state_reg.st)
            RX_IDLE: begin
                // Wait for the start byte
                if (rx_take && rx_data == FRAME_START) begin
                    state_next.cs = rx_data;
                    state_next.st = RX_CMD;
                end
            end
            RX_CMD: begin
                if (rx_take) begin
                    state_next.cmd = rx_data;
                    state_next.cs = state_reg.cs ^ rx_data;
                    state_next.index = 8'h00;
                    state_next.value = 8'h00;
                    state_next.st = RX_LEN_LO;
                end
            end
            RX_LEN_LO: begin
                // Length low byte first
                if (rx_take) begin
                    state_next.len[7:0] = rx_data;
                    state_next.cs = state_reg.cs ^ rx_data;
                    state_next.st = RX_LEN_HI;
                end
            end
            RX_LEN_HI: begin
                if (rx_take) begin
                    state_next.len[15:8] = rx_data;
                    state_next.cs = state_reg.cs ^ rx_data;
                    state_next.cnt = 16'h0000;
                    // Empty payload goes straight to the checksum
                    state_next.st = ({rx_data, state_reg.len[7:0]} == 16'h0000) ? RX_CSUM
                        : RX_PAYLOAD;
                end
            end
            RX_PAYLOAD: begin
                // First byte index, second value, rest ignored
                if (rx_take) begin
                    if (state_reg.cnt == 16'h0000) begin
                        state_next.index = rx_data;
                    end
                    if (state_reg.cnt == 16'h0001) begin
                        state_next.value = rx_data;
                    end
                    state_next.cs = state_reg.cs ^ rx_data;
                    state_next.cnt = state_reg.cnt + 16'h0001;
                    if (state_reg.cnt + 16'h0001 == state_reg.len) begin
                        state_next.st = RX_CSUM;
                    end
                end
            end
            RX_CSUM: begin
                if (rx_take) begin
                    state_next.st = RX_IDLE;
                    state_next.r_pos = POS_START;
                    state_next.r_cs = 8'h00;
                    state_next.r_two = 1'b0;
                    state_next.r_status = STATUS_FAIL;
                    state_next.r_value = 8'h00;
                    if (rx_data == state_reg.cs) begin
                        if (state_reg.cmd == setting_write_request) begin
                            state_next.st = RX_RESP;
                            state_next.r_cmd = setting_write_confirm;
                            if (settings_ok && state_reg.len >= 16'h0002) begin
                                state_next.r_status = STATUS_OK;
                                case (state_reg.index)
                                    IDX_SECURITY: state_next.security = state_reg.value;
                                    IDX_SCAN: state_next.scan = state_reg.value & SCAN_WRITE_MASK;
                                    IDX_BEACON: state_next.beacon = state_reg.value;
                                    default: state_next.r_status = STATUS_FAIL;
                                endcase
                            end
                        end else if (state_reg.cmd == setting_read_request) begin
                            state_next.st = RX_RESP;
                            state_next.r_cmd = setting_read_confirm;
                            if (settings_ok && state_reg.len >= 16'h0001) begin
                                state_next.r_status = STATUS_OK;
                                state_next.r_two = 1'b1;
                                case (state_reg.index)
                                    IDX_SECURITY: state_next.r_value = state_reg.security;
                                    IDX_SCAN: state_next.r_value = state_reg.scan;
                                    IDX_BEACON: state_next.r_value = state_reg.beacon;
                                    default: state_next.r_value = 8'h00;
                                endcase
                            end
                        end
                    end
                end
            end
            RX_RESP: begin
                // Send one response byte at a time
                if (!state_reg.tx_valid) begin
                    state_next.tx_data = resp_byte;
                    state_next.tx_valid = 1'b1;
                end else if (tx_take) begin
                    state_next.r_cs = state_reg.r_cs ^ state_reg.tx_data;
                    state_next.tx_valid = 1'b0;
                    state_next.r_pos = state_reg.r_pos + 3'h1;
                    if (state_reg.r_pos == last_pos) begin
                        state_next.st = RX_IDLE;
                    end
                end
            end
            default: begin
                state_next.st = RX_IDLE;
            end
        endcase

        // Radio packet handling while scanning
        if (adv.valid && scan_running) begin
            state_next.rep.sender_radio_address = adv.sender_radio_address;
            state_next.rep.content_tag = adv.content_tag;
            state_next.rep.rssi = adv.rssi;
            state_next.rep.tx_level = adv.tx_level;
            if (active_now && !adv.scan_rsp) begin
                state_next.scan_req = 1'b1;
                state_next.scan_addr = adv.sender_radio_address;
            end
            case (state_reg.beacon)
                BEACON_INTERPRET: begin
                    state_next.rep.kind = REP_BEACON;
                    state_next.rep_valid = adv.family;
                end
                BEACON_RAW: begin
                    state_next.rep.kind = REP_RAW;
                    state_next.rep_valid = 1'b1;
                end
                BEACON_FILTERED: begin
                    state_next.rep.kind = REP_BEACON;
                    state_next.rep_valid = adv.family && !duplicate;
                end
                BEACON_SIGNAL: begin
                    state_next.rep.kind = REP_SIGNAL;
                    state_next.rep_valid = adv.spp_uuid;
                end
                default: begin
                    // off and reserved codes report nothing
                    state_next.rep_valid = 1'b0;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_reg <= '0;
            state_reg.st <= RX_IDLE;
            state_reg.security <= SECURITY_RESET;
            state_reg.scan <= SCAN_RESET;
            state_reg.beacon <= BEACON_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

endmodule // radio_scan_beacon_settings

// ==== tb/scan_beacon_monitor.sv ====
// Port checks for the scan and beacon settings block
`timescale 1ns/1ps
module scan_beacon_monitor
    import scan_beacon_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic rx_ready,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic scan_running,
    input wire adv_s adv,
    input wire logic active_scan,
    input wire logic scan_req,
    input wire logic [47:0] scan_req_addr,
    input wire report_s report,
    input wire logic report_valid
);
    // One clock domain, one reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    scan_req_cause_a:
    assert property (scan_req |-> $past(adv.valid && scan_running && active_scan
        && !adv.scan_rsp)) else $error("scan request without an advertisement");
    scan_req_due_a:
    assert property (adv.valid && scan_running && active_scan && !adv.scan_rsp |=> scan_req
        && scan_req_addr == $past(adv.sender_radio_address)) else $error("scan request missed");
    no_passive_req_a:
    assert property (adv.valid && !active_scan |=> !scan_req)
        else $error("scan request while passive");
    report_cause_a:
    assert property (report_valid |-> $past(adv.valid && scan_running)
        && report.sender_radio_address == $past(adv.sender_radio_address)
        && report.rssi == $past(adv.rssi)) else $error("report without matching packet");
    report_signal_a:
    assert property (report_valid && report.kind == REP_SIGNAL |-> $past(adv.spp_uuid))
        else $error("signal report without vendor uuid");
    report_family_a:
    assert property (report_valid && report.kind == REP_BEACON |-> $past(adv.family))
        else $error("beacon report from foreign sender");
    tx_hold_a:
    assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("reply byte dropped before taken");
    tx_gap_a:
    assert property (tx_valid && tx_ready |=> !tx_valid) else $error("reply byte gap missing");
    rx_block_a:
    assert property (tx_valid |-> !rx_ready) else $error("host link open during reply");
    tx_first_a:
    assert property ($fell(rx_ready) |-> ##[0:1] (tx_valid && tx_data == FRAME_START))
        else $error("reply does not open with start byte");
endmodule // scan_beacon_monitor

bind radio_scan_beacon_settings scan_beacon_monitor u_mon (.clk(clk), .rst_b(rst_b),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .scan_running(scan_running), .adv(adv), .active_scan(active_scan), .scan_req(scan_req),
    .scan_req_addr(scan_req_addr), .report(report), .report_valid(report_valid));

// ==== tb/host_link_model.sv ====
// Host controller model: sends command frames and collects replies
`timescale 1ns/1ps
module host_link_model (
    input wire logic clk,
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready
);
    logic [7:0] rsp[$]; // Bytes of the last reply

    // Idle link at time zero
    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
        tx_ready = 1'b1;
    end

    // Send one frame; bad spoils the checksum
    task automatic send(input logic [7:0] cmd, len, idx, val, input logic bad);
        logic [7:0] b[$];
        logic [7:0] cs;
        repeat (2) @(posedge clk);
        b = '{8'h02, cmd, len, 8'h00};
        if (len > 8'h00) b.push_back(idx);
        if (len > 8'h01) b.push_back(val);
        cs = 8'h00;
        foreach (b[i]) cs = cs ^ b[i];
        b.push_back(bad ? ~cs : cs);
        foreach (b[i]) begin
            @(posedge clk);
            rx_data <= b[i];
            rx_valid <= 1'b1;
        end
        @(posedge clk);
        rx_valid <= 1'b0;
        // Released line flips so a stale byte never looks valid
        rx_data <= ~rx_data;
    endtask

    // Collect one reply; slow stalls every other cycle
    task automatic get(input logic slow);
        rsp.delete();
        for (int n = 0; n < 200; n++) begin
            @(negedge clk);
            if (tx_valid && tx_ready) rsp.push_back(tx_data);
            if (rsp.size() > 4 && rsp.size() == rsp[2] + 5) break;
            @(posedge clk);
            tx_ready <= slow ? ~tx_ready : 1'b1;
        end
        @(posedge clk);
        tx_ready <= 1'b1;
    endtask
endmodule // host_link_model

// ==== tb/tb_top.sv ====
// Self-checking bench for the scan and beacon settings block
`timescale 1ns/1ps
module tb_top
    import scan_beacon_pkg::*;
;
    logic clk = 1'b0; // 200 MHz clock
    logic rst_b = 1'b0; // Active-low reset
    logic [7:0] rx_data, tx_data; // Frame bytes both ways
    logic rx_valid, rx_ready, tx_valid, tx_ready; // Byte handshakes
    logic scan_running; // Scan in progress
    adv_s adv; // Radio packet
    logic active_scan, scan_req, report_valid; // Radio side results
    logic [47:0] scan_req_addr; // Scan request target
    report_s report; // Host report
    int num_errors = 0; // Mismatch count
    int comparisons = 0; // Compare count

    // Clock generator
    always #2.5 clk = ~clk;

    radio_scan_beacon_settings u_dut (.clk(clk), .rst_b(rst_b), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .scan_running(scan_running), .adv(adv), .active_scan(active_scan),
        .scan_req(scan_req), .scan_req_addr(scan_req_addr), .report(report),
        .report_valid(report_valid));
    host_link_model u_host (.clk(clk), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));

    // Compare and count
    task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Print counts and verdict, then stop
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Run one request and compare the whole reply
    task automatic xfer(input logic [7:0] cmd, idx, val, st, input logic slow);
        logic [7:0] e[$];
        logic [7:0] cs;
        logic rd;
        u_host.send(cmd, cmd == setting_write_request ? 8'h02 : 8'h01, idx, val, 1'b0);
        u_host.get(slow);
        rd = (cmd == setting_read_request) && (st == STATUS_OK);
        e = '{8'h02, cmd | 8'h40, {7'h00, rd} + 8'h01, 8'h00, st};
        if (rd) e.push_back(val);
        cs = 8'h00;
        foreach (e[i]) cs = cs ^ e[i];
        e.push_back(cs);
        chk("reply length", u_host.rsp.size(), e.size());
        foreach (e[i]) chk("reply byte", u_host.rsp[i], e[i]);
    endtask

    // Offer one packet; f holds running, scan response, family, vendor uuid
    task automatic pkt(input logic [3:0] f, input logic [47:0] a, input logic [15:0] tag,
        input logic rep, input report_kind_e k, input logic req);
        @(posedge clk);
        scan_running <= f[3];
        adv <= '{1'b1, f[2], f[1], f[0], a, tag, 8'hc5, 8'h3a};
        @(posedge clk);
        adv.valid <= 1'b0;
        @(negedge clk);
        chk("report valid", report_valid, rep);
        if (rep) chk("report kind", report.kind, k);
        if (rep) chk("report address", report.sender_radio_address, a);
        if (rep) chk("report tag", report.content_tag, tag);
        if (rep) chk("report levels", {report.tx_level, report.rssi}, 16'h3ac5);
        chk("scan request", scan_req, req);
        if (req) chk("scan address", scan_req_addr, a);
    endtask

    // Settings after reset
    task automatic t_reset_values();
        // Look away from the edge that releases reset
        @(negedge clk);
        chk("active scan", active_scan, 1'b0);
        xfer(setting_read_request, IDX_SCAN, SCAN_RESET, STATUS_OK, 1'b0);
        xfer(setting_read_request, IDX_BEACON, BEACON_RESET, STATUS_OK, 1'b0);
        $display("test reset values done");
    endtask

    // Security byte, stalled host, unknown index
    task automatic t_security();
        xfer(setting_write_request, IDX_SECURITY, 8'h0b, STATUS_OK, 1'b1);
        xfer(setting_read_request, IDX_SECURITY, 8'h0b, STATUS_OK, 1'b1);
        xfer(setting_read_request, 8'h07, 8'h00, STATUS_FAIL, 1'b0);
        xfer(setting_write_request, 8'h07, 8'h00, STATUS_FAIL, 1'b0);
        $display("test security done");
    endtask

    // Scan bit, reserved bits, scan requests
    task automatic t_scan_flags();
        xfer(setting_write_request, IDX_SCAN, 8'hff, STATUS_OK, 1'b0);
        xfer(setting_read_request, IDX_SCAN, 8'h01, STATUS_OK, 1'b0);
        chk("active scan", active_scan, 1'b1);
        pkt(4'b1000, 48'h0a0b, 16'h9, 1'b0, REP_RAW, 1'b1);
        pkt(4'b1100, 48'h0a0b, 16'h9, 1'b0, REP_RAW, 1'b0);
        xfer(setting_write_request, IDX_SCAN, 8'h00, STATUS_OK, 1'b0);
        pkt(4'b1000, 48'h0a0c, 16'h9, 1'b0, REP_RAW, 1'b0);
        $display("test scan flags done");
    endtask

    // Beacon modes 1 to 4 and one reserved code
    task automatic t_modes();
        for (int m = 1; m <= 5; m++) begin
            xfer(setting_write_request, IDX_BEACON, m[7:0], STATUS_OK, 1'b0);
            xfer(setting_read_request, IDX_BEACON, m[7:0], STATUS_OK, 1'b0);
            chk("active scan", active_scan, m < 5);
            pkt(4'b1010, 48'h100 + m, 16'h1, m < 4, m == 2 ? REP_RAW : REP_BEACON, m < 5);
            pkt(4'b1010, 48'h100 + m, 16'h1, m < 3, m == 2 ? REP_RAW : REP_BEACON, m < 5);
            pkt(4'b1000, 48'h200 + m, 16'h2, m == 2, REP_RAW, m < 5);
            pkt(4'b1001, 48'h300 + m, 16'h3, m == 2 || m == 4, m == 4 ? REP_SIGNAL : REP_RAW,
                m < 5);
            pkt(4'b0010, 48'h400 + m, 16'h4, 1'b0, REP_RAW, 1'b0);
        end
        xfer(setting_write_request, IDX_BEACON, BEACON_RAW, STATUS_OK, 1'b0);
        // Host sets the scan bit itself for raw scan responses
        xfer(setting_write_request, IDX_SCAN, 8'h01, STATUS_OK, 1'b0);
        pkt(4'b1100, 48'h0a0d, 16'h7, 1'b1, REP_RAW, 1'b0);
        $display("test modes done");
    endtask

    // Store of 25 senders, oldest evicted
    task automatic t_store();
        xfer(setting_write_request, IDX_BEACON, BEACON_FILTERED, STATUS_OK, 1'b0);
        for (int i = 0; i < 26; i++) begin
            pkt(4'b1010, 48'h500 + i, 16'h5, 1'b1, REP_BEACON, 1'b1);
        end
        pkt(4'b1010, 48'h501, 16'h5, 1'b0, REP_BEACON, 1'b1);
        pkt(4'b1010, 48'h500, 16'h5, 1'b1, REP_BEACON, 1'b1);
        $display("test store done");
    endtask

    // Spoilt checksum gets no reply, link recovers
    task automatic t_refuse();
        u_host.send(setting_read_request, 8'h01, IDX_SCAN, 8'h00, 1'b1);
        for (int i = 0; i < 20; i++) begin
            @(negedge clk);
            chk("no reply", tx_valid, 1'b0);
        end
        xfer(setting_read_request, IDX_SCAN, 8'h01, STATUS_OK, 1'b1);
        $display("test refuse done");
    endtask

    // Main sequence
    initial begin
        scan_running = 1'b0;
        adv = '0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        t_reset_values();
        t_security();
        t_scan_flags();
        t_modes();
        t_store();
        t_refuse();
        wrap_up();
    end

    // Watchdog against a hang
    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        wrap_up();
    end
endmodule // tb_top
